// [rtl/pwp_pkg.sv]
package pwp_pkg;

  // Register offsets within each controller
  localparam logic [11:0] OFF_CLEAR   = 12'h000;
  localparam logic [11:0] OFF_SET     = 12'h004;

  // Guard bit positions, first controller
  localparam int          A_EXT_IRQ   = 6;
  localparam int          A_RTC       = 5;
  localparam int          A_WATCHDOG  = 4;
  localparam int          A_GEN_CLOCK = 3;
  localparam int          A_SYS_CTRL  = 2;
  localparam int          A_POWER_MGR = 1;

  // Guard bit positions, second controller
  localparam int          B_IO_PORT   = 3;
  localparam int          B_NVM_CTRL  = 2;
  localparam int          B_DEBUG_SU  = 1;

  // Implemented bit masks and reset values
  localparam logic [31:0] A_MASK      = 32'h0000007E;
  localparam logic [31:0] B_MASK      = 32'h0000000E;
  localparam logic [31:0] A_RESET     = 32'h00000000;
  localparam logic [31:0] B_RESET     = 32'h00000002;

  // Bus handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } pwp_state_e;

  // Peripheral bus request from the bridge
  typedef struct packed {
    logic        psel_a;
    logic        psel_b;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        debug;
  } pwp_apb_req_s;

  // Write check request from a guarded peripheral
  typedef struct packed {
    logic       valid;
    logic       ctrl_b;
    logic [4:0] index;
    logic       debug;
  } pwp_check_s;

endpackage : pwp_pkg

// [rtl/pwp_write_protect.sv]
`timescale 1ns/1ps
// How it works
// - Written zeros leave protection unchanged
// - Clear register ones remove protection
// - First controller set register, six guard bits
// - Second controller guards three peripherals
// - Second clear register resets to 0x2
// - Second set register shows same reset
// - Bit one blocks writes, zero allows
// - Set ones protect; both offsets read same
// - Protected peripheral writes discarded with error
// - Double protect or unprotect gives error, except on debugger accesses
// - Debugger accesses bypass write protection
module pwp_write_protect (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // Peripheral bus slave
  input  wire pwp_pkg::pwp_apb_req_s apb_in,
  output logic [31:0]                prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Peripheral write check
  input  wire pwp_pkg::pwp_check_s   chk_in,
  output logic                       chk_grant_out,
  output logic                       chk_err_out,
  // Protection state
  output logic [6:0]                 prot_a_out,
  output logic [3:0]                 prot_b_out
);

  pwp_pkg::pwp_state_e st_q, st_d;
  logic [31:0]         prot_a_q, prot_a_d;
  logic [31:0]         prot_b_q, prot_b_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                pready_q, pready_d;
  logic                perr_q, perr_d;
  logic                grant_q, grant_d;
  logic                cerr_q, cerr_d;
  logic                acc;
  logic                is_clr;
  logic                is_set;
  logic                mapped;
  logic                dbl;
  logic [31:0]         cur;
  logic [31:0]         mask;
  logic [31:0]         wone;
  logic [31:0]         nxt;
  logic [31:0]         cvec;

  // Byte strobes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // Offset decode, one bit per register kind
  function automatic logic offset_is(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction : offset_is

  // Access decode and register update
  always_comb begin
    acc    = (apb_in.psel_a | apb_in.psel_b) & apb_in.penable & (st_q == pwp_pkg::ST_IDLE);
    is_clr = offset_is(apb_in.paddr, pwp_pkg::OFF_CLEAR);
    is_set = offset_is(apb_in.paddr, pwp_pkg::OFF_SET);
    mapped = (is_clr | is_set) & (apb_in.psel_a ^ apb_in.psel_b);
    cur    = apb_in.psel_b ? prot_b_q : prot_a_q;
    mask   = apb_in.psel_b ? pwp_pkg::B_MASK : pwp_pkg::A_MASK;
    wone   = apb_in.pwdata & strb_mask(apb_in.pstrb) & mask;
    dbl    = ~apb_in.debug & ((is_set & (|(wone & cur)))
                            | (is_clr & (|(wone & ~cur))));
    nxt    = is_set ? (cur | wone) : (cur & ~wone);
    prot_a_d = prot_a_q;
    prot_b_d = prot_b_q;
    st_d     = pwp_pkg::ST_IDLE;
    rdata_d  = rdata_q;
    perr_d   = 1'b0;
    if (acc) begin
      st_d    = pwp_pkg::ST_RESP;
      rdata_d = (mapped & ~apb_in.pwrite) ? (cur & mask) : 32'h00000000;
      perr_d  = ~mapped | (apb_in.pwrite & dbl);
      if (apb_in.pwrite & mapped & ~dbl) begin
        if (apb_in.psel_b) begin
          prot_b_d = nxt;
        end else begin
          prot_a_d = nxt;
        end
      end
    end
    pready_d = (st_d == pwp_pkg::ST_RESP);
  end

  // Peripheral write check against guard bits
  always_comb begin
    cvec    = chk_in.ctrl_b ? prot_b_q : prot_a_q;
    cerr_d  = chk_in.valid & ~chk_in.debug & cvec[chk_in.index];
    grant_d = chk_in.valid & ~cerr_d;
  end

  // State registers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q     <= pwp_pkg::ST_IDLE;
      prot_a_q <= pwp_pkg::A_RESET;
      prot_b_q <= pwp_pkg::B_RESET;
      rdata_q  <= 32'h00000000;
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      grant_q  <= 1'b0;
      cerr_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      prot_a_q <= prot_a_d;
      prot_b_q <= prot_b_d;
      rdata_q  <= rdata_d;
      pready_q <= pready_d;
      perr_q   <= perr_d;
      grant_q  <= grant_d;
      cerr_q   <= cerr_d;
    end
  end

  // Outputs straight from flops
  assign prdata_out    = rdata_q;
  assign pready_out    = pready_q;
  assign pslverr_out   = perr_q;
  assign chk_grant_out = grant_q;
  assign chk_err_out   = cerr_q;
  assign prot_a_out    = prot_a_q[6:0];
  assign prot_b_out    = prot_b_q[3:0];

  // Helper flag for the first cycle after reset
  logic seen_q;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  // Assertion clock and reset
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // Register update and response checks
  AST_ZERO_WRITE_KEEPS: assert property (
    acc && apb_in.pwrite && (wone == 32'h00000000)
    |=> (prot_a_q == $past(prot_a_q)) && (prot_b_q == $past(prot_b_q)))
    else $error("zero write changed protection");

  AST_CLEAR_REMOVES: assert property (
    acc && apb_in.pwrite && mapped && is_clr && !dbl
    |=> ((($past(apb_in.psel_b) ? prot_b_q : prot_a_q) & $past(wone)) == 32'h00000000))
    else $error("clear write left protection set");

  AST_A_READ_VALUE: assert property (
    acc && !apb_in.pwrite && mapped && apb_in.psel_a
    |=> pready_out && !pslverr_out && (prdata_out == (prot_a_q & pwp_pkg::A_MASK)))
    else $error("first controller read value wrong");

  AST_UNUSED_ZERO: assert property (
    ((prot_b_q & ~pwp_pkg::B_MASK) == 32'h00000000)
    && ((prot_a_q & ~pwp_pkg::A_MASK) == 32'h00000000))
    else $error("unused protect bit set");

  AST_B_RESET: assert property (
    !seen_q |-> (prot_b_q == pwp_pkg::B_RESET) && (prot_a_q == pwp_pkg::A_RESET))
    else $error("protect reset value wrong");

  AST_SET_PROTECTS: assert property (
    acc && apb_in.pwrite && mapped && is_set && !perr_d
    |=> ((($past(apb_in.psel_b) ? prot_b_q : prot_a_q) & $past(wone)) == $past(wone)))
    else $error("set write did not protect");

  AST_BLOCKED_WRITE: assert property (
    chk_in.valid && !chk_in.debug && cvec[chk_in.index]
    |=> chk_err_out && !chk_grant_out)
    else $error("protected write not refused");

  AST_DOUBLE_ERROR: assert property (
    acc && apb_in.pwrite && mapped && !apb_in.debug && is_set && (|(wone & cur))
    |=> pready_out && pslverr_out && (prot_a_q == $past(prot_a_q))
        && (prot_b_q == $past(prot_b_q)))
    else $error("double protect not flagged");

  AST_DEBUG_BYPASS: assert property (
    chk_in.valid && chk_in.debug |=> chk_grant_out && !chk_err_out)
    else $error("debugger write refused");

  // Further bus and check port checks
  AST_DOUBLE_CLEAR: assert property (
    acc && apb_in.pwrite && mapped && !apb_in.debug && is_clr && (|(wone & ~cur))
    |=> pready_out && pslverr_out && (prot_a_q == $past(prot_a_q))
        && (prot_b_q == $past(prot_b_q)))
    else $error("double unprotect not flagged");

  AST_B_READ_VALUE: assert property (
    acc && !apb_in.pwrite && mapped && apb_in.psel_b
    |=> pready_out && !pslverr_out && (prdata_out == (prot_b_q & pwp_pkg::B_MASK)))
    else $error("second controller read value wrong");

  AST_UNMAPPED_ERROR: assert property (
    acc && !mapped
    |=> pready_out && pslverr_out && (prdata_out == 32'h00000000)
        && (prot_a_q == $past(prot_a_q)) && (prot_b_q == $past(prot_b_q)))
    else $error("unmapped access not refused");

  AST_READY_PULSE: assert property (
    pready_out |=> !pready_out)
    else $error("bus response held too long");

  AST_CHECK_IDLE: assert property (
    !chk_in.valid |=> !chk_grant_out && !chk_err_out)
    else $error("check answer without request");

  AST_CHECK_GRANT: assert property (
    chk_in.valid && !cvec[chk_in.index] |=> chk_grant_out && !chk_err_out)
    else $error("unprotected write refused");

  // Main scenarios reached
  COV_UNPROTECT_DEBUG_UNIT: cover property (
    acc && apb_in.pwrite && apb_in.psel_b && is_clr && wone[pwp_pkg::B_DEBUG_SU]);
  COV_DOUBLE_SET: cover property (acc && apb_in.pwrite && is_set && dbl);
  COV_BLOCKED: cover property (chk_err_out);
  COV_DEBUG_WRITE: cover property (chk_in.valid && chk_in.debug && cvec[chk_in.index]);
  COV_UNMAPPED: cover property (acc && !mapped);

endmodule : pwp_write_protect

// [tb/pwp_bus_master.sv]
`timescale 1ns/1ps
// Bus master in the processor's place
module pwp_bus_master (
  // Clock
  input  wire logic                  clk_sys_in,
  // Slave answer
  input  wire logic [31:0]           prdata_in,
  input  wire logic                  pready_in,
  input  wire logic                  pslverr_in,
  // Request
  output pwp_pkg::pwp_apb_req_s      apb_out
);
  // Idle bus at time zero
  initial apb_out = '0;
  // Setup, access, hold until ready
  task automatic xfer(input logic b, wr, dbg, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys_in);
    apb_out <= '{!b, b, 1'h0, wr, a, d, 4'hF, dbg};
    @(posedge clk_sys_in);
    apb_out.penable <= 1'h1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys_in);
      if (pready_in === 1'h1) break;
    end
    // No ready within the limit reads as unknown and fails the compare
    rd = (n < 8) ? prdata_in : 32'hXXXXXXXX;
    err = (n < 8) ? pslverr_in : 1'hX;
    // Released address and data show changed values
    apb_out.paddr <= ~a;
    apb_out.psel_a <= 1'h0;
    apb_out.psel_b <= 1'h0;
    apb_out.penable <= 1'h0;
    apb_out.pwdata <= ~d;
  endtask : xfer
endmodule : pwp_bus_master

// [tb/tb_peripheral_write_protect_regs.sv]
`timescale 1ns/1ps
// Self-checking bench for the protect registers
module tb_peripheral_write_protect_regs;
  typedef struct packed {
    logic b; logic wr; logic dbg; logic [11:0] a; logic [31:0] d; logic err;
  } pwp_row_s;
  logic                  clk_sys_in = 1'h0;
  logic                  rstn_in    = 1'h0;
  pwp_pkg::pwp_check_s   chk_in     = '0;
  pwp_pkg::pwp_apb_req_s apb_in;
  logic [31:0]           prdata_out;
  logic                  pready_out, pslverr_out, chk_grant_out, chk_err_out, err;
  logic [6:0]            prot_a_out;
  logic [3:0]            prot_b_out;
  logic [31:0]           rd;
  int                    error_cnt = 0;
  int                    tests_run = 0;
  int                    cycles    = 0;
  // Rows: controller, write, debug, offset, data or read value, error
  pwp_row_s rows [16] = '{
    '{1'h0, 1'h0, 1'h0, 12'h004, 32'h00, 1'h0}, '{1'h1, 1'h0, 1'h0, 12'h000, 32'h02, 1'h0},
    '{1'h1, 1'h0, 1'h0, 12'h004, 32'h02, 1'h0}, '{1'h0, 1'h1, 1'h0, 12'h004, 32'h7E, 1'h0},
    '{1'h0, 1'h0, 1'h0, 12'h000, 32'h7E, 1'h0}, '{1'h0, 1'h1, 1'h0, 12'h004, 32'h02, 1'h1},
    '{1'h0, 1'h1, 1'h0, 12'h000, 32'h10, 1'h0}, '{1'h0, 1'h0, 1'h0, 12'h004, 32'h6E, 1'h0},
    '{1'h0, 1'h1, 1'h0, 12'h000, 32'h10, 1'h1}, '{1'h0, 1'h1, 1'h0, 12'h004, 32'hFFFFFF80, 1'h0},
    '{1'h0, 1'h0, 1'h0, 12'h000, 32'h6E, 1'h0}, '{1'h0, 1'h1, 1'h1, 12'h004, 32'h02, 1'h0},
    '{1'h1, 1'h1, 1'h0, 12'h000, 32'h02, 1'h0}, '{1'h1, 1'h1, 1'h0, 12'h004, 32'h0C, 1'h0},
    '{1'h1, 1'h0, 1'h0, 12'h004, 32'h0C, 1'h0}, '{1'h0, 1'h0, 1'h0, 12'h008, 32'h00, 1'h1}};
  // Clock
  always #5 clk_sys_in = ~clk_sys_in;
  // Design and bus master
  pwp_write_protect pwp_write_protect_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .chk_in(chk_in), .chk_grant_out(chk_grant_out),
    .chk_err_out(chk_err_out), .prot_a_out(prot_a_out), .prot_b_out(prot_b_out));
  pwp_bus_master pwp_bus_master_i (.clk_sys_in(clk_sys_in), .prdata_in(prdata_out),
    .pready_in(pready_out), .pslverr_in(pslverr_out), .apb_out(apb_in));
  // Verdict and end of run
  task automatic complete_run();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Word compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // One guarded write check, answer one cycle later
  task automatic chk_req(input logic b, input logic [4:0] idx, input logic dbg, input logic e);
    @(posedge clk_sys_in);
    chk_in <= '{1'h1, b, idx, dbg};
    @(posedge clk_sys_in);
    chk_in.valid <= 1'h0;
    #1;
    cmp({30'h0, chk_grant_out, chk_err_out}, {30'h0, !e, e});
  endtask : chk_req
  // Hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    foreach (rows[i]) begin
      pwp_bus_master_i.xfer(rows[i].b, rows[i].wr, rows[i].dbg, rows[i].a, rows[i].d, rd, err);
      cmp({31'h0, err}, {31'h0, rows[i].err});
      if (!rows[i].wr) cmp(rd, rows[i].d);
    end
    cmp({25'h0, prot_a_out}, 32'h6E);
    cmp({28'h0, prot_b_out}, 32'h0C);
    chk_req(1'h0, 5'h05, 1'h0, 1'h1);
    chk_req(1'h0, 5'h05, 1'h1, 1'h0);
    chk_req(1'h0, 5'h04, 1'h0, 1'h0);
    chk_req(1'h1, 5'h03, 1'h0, 1'h1);
    @(posedge clk_sys_in) rstn_in <= 1'h0;
    @(posedge clk_sys_in);
    #1;
    cmp({21'h0, prot_b_out, prot_a_out}, 32'h100);
    cmp({28'h0, pready_out, pslverr_out, chk_grant_out, chk_err_out}, 32'h0);
    cmp(prdata_out, 32'h0);
    // Release in mid-run at an edge, then two idle edges
    @(posedge clk_sys_in) rstn_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    cmp({21'h0, prot_b_out, prot_a_out}, 32'h100);
    pwp_bus_master_i.xfer(1'h1, 1'h0, 1'h0, 12'h000, 32'h0, rd, err);
    cmp(rd, 32'h02);
    pwp_bus_master_i.xfer(1'h1, 1'h1, 1'h0, 12'h004, 32'h02, rd, err);
    cmp({31'h0, err}, 32'h1);
    complete_run();
  end
endmodule : tb_peripheral_write_protect_regs
